// >>> design/timer16_defs.vh
// constants for the 16-bit timer counting and waveform logic
`ifndef TIMER16_DEFS_VH
`define TIMER16_DEFS_VH
`define MODE_NORMAL     4'h0
`define MODE_FAST8      4'h5
`define MODE_FAST9      4'h6
`define MODE_FAST10     4'h7
`define MODE_CTC_CMPA   4'h4
`define MODE_CTC_CAPT   4'hc
`define MODE_FAST_CAPT  4'he
`define MODE_FAST_CMPA  4'hf
`define TOP_FIXED8      16'h00ff
`define TOP_FIXED9      16'h01ff
`define TOP_FIXED10     16'h03ff
`define COUNT_MAX       16'hffff
`define COUNT_BOTTOM    16'h0000
`define ACT_NONE        2'h0
`define ACT_TOGGLE      2'h1
`define ACT_CLEAR       2'h2
`define ACT_SET         2'h3
`define PRE_STOP        3'h0
`define PRE_DIV1        3'h1
`define PRE_DIV8        3'h2
`define PRE_DIV64       3'h3
`define PRE_DIV256      3'h4
`define PRE_DIV1024     3'h5
`define DIV8_LAST       10'h007
`define DIV64_LAST      10'h03f
`define DIV256_LAST     10'h0ff
`define DIV1024_LAST    10'h3ff
`endif

// >>> design/timer16_prescaler.v
// prescaler producing the timer clock enable from the i/o clock
`timescale 1ns/1ps
`include "timer16_defs.vh"
module timer16_prescaler
(
  input  wire       clk,        // i/o clock
  input  wire       rstn,       // async reset, active low
  input  wire [2:0] clockSel,   // prescaler select
  output reg        tickEn      // one-cycle timer clock enable
);

  reg  [9:0] div_reg;
  reg  [9:0] lastVal;

  ////////////////////////////////////////////////////////////////////////////
  // terminal count for the chosen division
  always @*
  begin
    case (clockSel)
      `PRE_DIV8:    lastVal = `DIV8_LAST;
      `PRE_DIV64:   lastVal = `DIV64_LAST;
      `PRE_DIV256:  lastVal = `DIV256_LAST;
      `PRE_DIV1024: lastVal = `DIV1024_LAST;
      default:      lastVal = 10'h000;
    endcase
  end

  // free divider; stop or reserved selects give no ticks
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      div_reg <= 10'h000;
      tickEn  <= 1'b0;
    end
    else if (clockSel == `PRE_STOP || clockSel > `PRE_DIV1024)
    begin
      div_reg <= 10'h000;
      tickEn  <= 1'b0;
    end
    else if (div_reg >= lastVal)
    begin
      div_reg <= 10'h000;
      tickEn  <= 1'b1;                               // [RQ9]
    end
    else
    begin
      div_reg <= div_reg + 10'h001;
      tickEn  <= 1'b0;
    end
  end

endmodule // timer16_prescaler

// >>> design/timer16_count_modes.v
// 16-bit timer counter: normal, clear-on-compare and fast pwm modes
// Notes on behaviour
// [RQ1] mode field alone sets counting; output action only shapes outputs
// [RQ2] mode 0 counts up forever, wrapping from ffff to 0000
// [RQ3] normal mode sets overflow flag when count becomes zero; only set
// [RQ4] software may write the count at any time in normal mode
// [RQ5] ctc clears counter at top: compare-a in mode 4, capture in 12
// [RQ6] ctc sets the flag of whichever register defines top
// [RQ7] ctc top writes act at once; a low top forces wrap first
// [RQ8] ctc action 1 toggles channel a; pin shows it only when output
// [RQ9] timer enable comes from a 1/8/64/256/1024 prescaler
// [RQ10] ctc sets overflow flag when count passes max to zero
// [RQ11] fast pwm counts bottom to top, clears next tick; fixed/reg top
// [RQ12] fast pwm non-inverting clears on match, sets at bottom; inverted
// [RQ13] software keeps a register top at 0003 or more
// [RQ14] fast pwm sets overflow at top, plus the top register flag
// [RQ15] fast pwm sets each channel flag on its compare match
// [RQ16] fixed top masks compare writes above the resolution
// [RQ17] software keeps top at or above every compare value
// [RQ18] capture top is unbuffered in fast pwm; low value forces wrap
// [RQ19] fast pwm compare-a writes buffered, loaded at top with clear
// [RQ20] compare buffering on in pwm modes, off in normal and ctc
// [RQ21] pwm action 2 non-inverted, 3 inverted, 0 leaves output alone
// [RQ22] count write blocks all compare matches in the next timer tick
// [RQ23] all state runs on clk with tick enable; reset clears it; pins, register writes and flag clears act on every clk
`timescale 1ns/1ps
`include "timer16_defs.vh"
module timer16_count_modes
(
  input  wire        clk,          // i/o clock, 40 mhz
  input  wire        rstn,         // async reset, active low
  input  wire [3:0]  waveMode,     // waveform mode field
  input  wire [1:0]  actionA,      // channel a output action field
  input  wire [1:0]  actionB,      // channel b output action field
  input  wire [2:0]  clockSel,     // prescaler select, 0 stops
  input  wire        countWr,      // write strobe for the count
  input  wire [15:0] countWrData,  // value to write to the count
  input  wire        cmpAWr,       // write strobe for compare a
  input  wire        cmpBWr,       // write strobe for compare b
  input  wire        captWr,       // write strobe for capture top
  input  wire [15:0] wrData,       // data for compare/capture writes
  input  wire        ovfClr,       // overflow flag cleared by service
  input  wire        cmpAClr,      // compare a flag clear
  input  wire        cmpBClr,      // compare b flag clear
  input  wire        captClr,      // capture flag clear
  input  wire        pinDirA,      // channel a pin direction, 1 drives
  input  wire        pinDirB,      // channel b pin direction, 1 drives
  output reg  [15:0] count,        // counter value
  output reg  [15:0] cmpA,         // active compare a value
  output reg  [15:0] cmpB,         // active compare b value
  output reg  [15:0] captTop,      // capture top register
  output reg         ovfFlag,      // overflow flag
  output reg         cmpAFlag,     // compare a flag
  output reg         cmpBFlag,     // compare b flag
  output reg         captFlag,     // capture flag
  output reg         outA,         // channel a output register
  output reg         outB,         // channel b output register
  output reg         pinOutA,      // channel a pin level
  output reg         pinOeA,       // channel a pin enable
  output reg         pinOutB,      // channel b pin level
  output reg         pinOeB        // channel b pin enable
);

  wire        tickEn;
  reg  [15:0] cmpABuf_reg;
  reg  [15:0] cmpBBuf_reg;
  reg         block_reg;
  reg  [15:0] top;
  reg         isPwm;
  reg         isCtc;
  reg         topIsCmpA;
  reg         topIsCapt;
  reg  [15:0] wrMasked;
  reg  [15:0] count_next;
  reg         atTop;
  reg         matchA;
  reg         matchB;
  reg         setOvf;
  reg         setA;
  reg         setB;
  reg         setCapt;
  reg         outA_next;
  reg         outB_next;

  ////////////////////////////////////////////////////////////////////////////
  // timer clock enable source
  timer16_prescaler prescaler
  (
    .clk      (clk),
    .rstn     (rstn),
    .clockSel (clockSel),
    .tickEn   (tickEn)
  );

  ////////////////////////////////////////////////////////////////////////////
  // fixed-top mask for the fast pwm fixed resolutions
  function [15:0] fixMask;
    input [3:0]  mode;
    input [15:0] val;
    begin
      case (mode)
        `MODE_FAST8:  fixMask = val & `TOP_FIXED8;   // [RQ16]
        `MODE_FAST9:  fixMask = val & `TOP_FIXED9;   // [RQ16]
        `MODE_FAST10: fixMask = val & `TOP_FIXED10;  // [RQ16]
        default:      fixMask = val;
      endcase
    end
  endfunction

  // waveform action in pwm: next level on match or bottom
  function pwmLevel;
    input [1:0] act;
    input       atMatch;
    input       cur;
    begin
      case (act)
        `ACT_CLEAR: pwmLevel = ~atMatch;             // [RQ12] [RQ21]
        `ACT_SET:   pwmLevel = atMatch;              // [RQ12] [RQ21]
        default:    pwmLevel = cur;                  // [RQ21]
      endcase
    end
  endfunction

  // non-pwm action on a compare match
  function cmpLevel;
    input [1:0] act;
    input       cur;
    begin
      case (act)
        `ACT_TOGGLE: cmpLevel = ~cur;                // [RQ8]
        `ACT_CLEAR:  cmpLevel = 1'b0;
        `ACT_SET:    cmpLevel = 1'b1;
        default:     cmpLevel = cur;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // mode decode: top source and buffering depend on the mode only
  always @*
  begin
    isPwm     = 1'b0;
    isCtc     = 1'b0;
    topIsCmpA = 1'b0;
    topIsCapt = 1'b0;
    top       = `COUNT_MAX;                          // [RQ1] [RQ2]
    case (waveMode)
      `MODE_CTC_CMPA:
      begin
        isCtc     = 1'b1;
        topIsCmpA = 1'b1;
        top       = cmpA;                            // [RQ5]
      end
      `MODE_CTC_CAPT:
      begin
        isCtc     = 1'b1;
        topIsCapt = 1'b1;
        top       = captTop;                         // [RQ5]
      end
      `MODE_FAST8:
      begin
        isPwm = 1'b1;
        top   = `TOP_FIXED8;                         // [RQ11]
      end
      `MODE_FAST9:
      begin
        isPwm = 1'b1;
        top   = `TOP_FIXED9;                         // [RQ11]
      end
      `MODE_FAST10:
      begin
        isPwm = 1'b1;
        top   = `TOP_FIXED10;                        // [RQ11]
      end
      `MODE_FAST_CAPT:
      begin
        isPwm     = 1'b1;
        topIsCapt = 1'b1;
        top       = captTop;                         // [RQ11] [RQ18]
      end
      `MODE_FAST_CMPA:
      begin
        isPwm     = 1'b1;
        topIsCmpA = 1'b1;
        top       = cmpA;                            // [RQ11]
      end
      default:
      begin
        top = `COUNT_MAX;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next count, matches and flag events for one timer tick
  // a top below the count is simply missed, so the count wraps at ffff
  always @*
  begin
    wrMasked  = fixMask(waveMode, wrData);
    atTop     = (count == top) && !block_reg;        // [RQ22]
    matchA    = (count == cmpA) && !block_reg;       // [RQ22]
    matchB    = (count == cmpB) && !block_reg;       // [RQ22]
    setOvf    = 1'b0;
    setA      = 1'b0;
    setB      = 1'b0;
    setCapt   = 1'b0;
    count_next = count + 16'h0001;                   // [RQ2] [RQ7] [RQ18]
    if ((isCtc || isPwm) && atTop)
    begin
      count_next = `COUNT_BOTTOM;                    // [RQ5] [RQ11]
      setA       = topIsCmpA;                        // [RQ6] [RQ14]
      setCapt    = topIsCapt;                        // [RQ6] [RQ14]
    end
    if (isPwm)
    begin
      setOvf = atTop;                                // [RQ14]
      setA   = setA | matchA;                        // [RQ15]
      setB   = matchB;                               // [RQ15]
    end
    else
    begin
      setOvf = (count == `COUNT_MAX);                // [RQ3] [RQ10]
      setA   = setA | (matchA && !topIsCmpA);
      setB   = matchB;
    end
    outA_next = outA;
    outB_next = outB;
    if (isPwm)
    begin
      if (topIsCmpA && actionA == `ACT_TOGGLE)
      begin
        if (matchA)
          outA_next = ~outA;
      end
      else if (matchA)
        outA_next = pwmLevel(actionA, 1'b1, outA);   // [RQ12]
      else if (atTop)
        outA_next = pwmLevel(actionA, 1'b0, outA);   // [RQ12]
      if (matchB)
        outB_next = pwmLevel(actionB, 1'b1, outB);   // [RQ12]
      else if (atTop)
        outB_next = pwmLevel(actionB, 1'b0, outB);   // [RQ12]
    end
    else
    begin
      if (matchA)
        outA_next = cmpLevel(actionA, outA);         // [RQ8]
      if (matchB)
        outB_next = cmpLevel(actionB, outB);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // counter and compare-block flag; a write wins over counting
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      count     <= `COUNT_BOTTOM;                    // [RQ23]
      block_reg <= 1'b0;
    end
    else if (countWr)
    begin
      count     <= countWrData;                      // [RQ4]
      block_reg <= 1'b1;                             // [RQ22]
    end
    else if (tickEn)
    begin
      count     <= count_next;                       // [RQ9] [RQ23]
      block_reg <= 1'b0;                             // [RQ22]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare and capture registers with pwm double buffering
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cmpA        <= 16'h0000;
      cmpB        <= 16'h0000;
      cmpABuf_reg <= 16'h0000;
      cmpBBuf_reg <= 16'h0000;
      captTop     <= 16'h0000;
    end
    else
    begin
      if (captWr)
        captTop <= wrData;                           // [RQ7] [RQ18]
      if (cmpAWr)
        cmpABuf_reg <= wrMasked;                     // [RQ16] [RQ19]
      if (cmpBWr)
        cmpBBuf_reg <= wrMasked;                     // [RQ16]
      if (!isPwm)
      begin
        if (cmpAWr)
          cmpA <= wrMasked;                          // [RQ20] [RQ7]
        if (cmpBWr)
          cmpB <= wrMasked;                          // [RQ20]
      end
      else if (tickEn && !countWr && atTop)
      begin
        cmpA <= cmpABuf_reg;                         // [RQ19] [RQ20]
        cmpB <= cmpBBuf_reg;                         // [RQ20]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flags: hardware set wins over a clear in the same cycle
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ovfFlag  <= 1'b0;                              // [RQ23]
      cmpAFlag <= 1'b0;
      cmpBFlag <= 1'b0;
      captFlag <= 1'b0;
    end
    else
    begin
      if (tickEn && !countWr && setOvf)
        ovfFlag <= 1'b1;                             // [RQ3] [RQ10] [RQ14]
      else if (ovfClr)
        ovfFlag <= 1'b0;                             // [RQ3]
      if (tickEn && !countWr && setA)
        cmpAFlag <= 1'b1;                            // [RQ6] [RQ15]
      else if (cmpAClr)
        cmpAFlag <= 1'b0;
      if (tickEn && !countWr && setB)
        cmpBFlag <= 1'b1;                            // [RQ15]
      else if (cmpBClr)
        cmpBFlag <= 1'b0;
      if (tickEn && !countWr && setCapt)
        captFlag <= 1'b1;                            // [RQ6] [RQ14]
      else if (captClr)
        captFlag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output registers and pins; the pin shows the output only when driven
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      outA    <= 1'b0;                               // [RQ23]
      outB    <= 1'b0;
      pinOutA <= 1'b0;
      pinOeA  <= 1'b0;
      pinOutB <= 1'b0;
      pinOeB  <= 1'b0;
    end
    else
    begin
      if (tickEn && !countWr)
      begin
        outA <= outA_next;                           // [RQ1] [RQ23]
        outB <= outB_next;
      end
      pinOutA <= outA;                               // [RQ8]
      pinOeA  <= pinDirA;                            // [RQ8]
      pinOutB <= outB;
      pinOeB  <= pinDirB;
    end
  end

endmodule // timer16_count_modes

// >>> verif/timer16_count_modes_sva.sv
// assertions on the ports of the 16-bit timer counting block
`timescale 1ns/1ps
module timer16_count_modes_chk
(
  input logic        clk,         // i/o clock
  input logic        rstn,        // async reset, active low
  input logic [3:0]  waveMode,    // mode field
  input logic [1:0]  actionA,     // action a
  input logic [1:0]  actionB,     // action b
  input logic [2:0]  clockSel,    // prescaler select
  input logic        countWr,     // count write
  input logic [15:0] countWrData, // count data
  input logic        ovfClr,      // overflow clear
  input logic        pinDirA,     // pin a direction
  input logic [15:0] count,       // counter
  input logic [15:0] cmpA,        // compare a
  input logic [15:0] cmpB,        // compare b
  input logic [15:0] captTop,     // capture top
  input logic        ovfFlag,     // overflow flag
  input logic        cmpAFlag,    // compare a flag
  input logic        captFlag,    // capture flag
  input logic        outA,        // output a
  input logic        outB,        // output b
  input logic        pinOutA,     // pin a level
  input logic        pinOeA       // pin a enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic wrPrev;
  logic selOk;
  logic go;
  logic run;
  logic blkPend;
  //////////////////////////////////////////////////////////////////////////
  // a tick is only certain once /1 has been selected for a whole cycle;
  // blkPend stays up after a count write until a known tick has passed,
  // so a write made while stopped still keeps the checks quiet
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wrPrev  <= 1'b0;
      selOk   <= 1'b0;
      blkPend <= 1'b0;
    end
    else
    begin
      wrPrev <= countWr;
      selOk  <= (clockSel == 3'h1);
      if (countWr)
        blkPend <= 1'b1;
      else if (selOk)
        blkPend <= 1'b0;
    end
  end
  assign go  = selOk && clockSel == 3'h1 && !countWr;
  assign run = go && !blkPend;
  //////////////////////////////////////////////////////////////////////////
  a_normal_wrap: assert property (waveMode == 4'h0 && run &&
    count == 16'hffff |=> count == 16'h0000 && ovfFlag) else $error("no wrap");
  a_ctc_a_top: assert property (waveMode == 4'h4 && run &&
    count == cmpA |=> count == 16'h0000 && cmpAFlag) else $error("ctc a top");
  a_ctc_capt_top: assert property (waveMode == 4'hc && run &&
    count == captTop |=> count == 16'h0000 && captFlag) else $error("ctc capt");
  a_ctc_toggle: assert property (waveMode == 4'h4 && run &&
    count == cmpA && actionA == 2'h1 |=> outA != $past(outA))
    else $error("no toggle");
  a_pin_follow: assert property (1'b1 |=> pinOeA == $past(pinDirA) &&
    pinOutA == $past(outA)) else $error("pin mismatch");
  a_fast_top: assert property (waveMode == 4'hf && run &&
    count == cmpA |=> count == 16'h0000 && ovfFlag && cmpAFlag)
    else $error("fast top");
  a_pwm_bottom: assert property (waveMode == 4'hf && run &&
    count == cmpA && count != cmpB && actionB == 2'h2 |=> outB)
    else $error("bottom set");
  a_flag_hold: assert property (ovfFlag && !ovfClr |=> ovfFlag)
    else $error("flag dropped");
  a_count_load: assert property (countWr |=>
    count == $past(countWrData)) else $error("count load");
  a_write_block: assert property (waveMode == 4'h4 && go && wrPrev &&
    count == cmpA && count != 16'hffff |=> count == $past(count) + 16'h1)
    else $error("match not blocked");
endmodule // timer16_count_modes_chk

// >>> verif/pin_load.sv
// external load on the channel a pin, pulled down when released
`timescale 1ns/1ps
module pin_load
(
  input  logic pinOutA, // driven level
  input  logic pinOeA,  // drive enable
  output logic lvl      // level seen by the load
);
  // pull-down wins while the pin is an input
  assign lvl = pinOeA ? pinOutA : 1'b0;
endmodule // pin_load

// >>> verif/timer16_count_modes_bench.sv
// self-checking bench for the 16-bit timer counting block
`timescale 1ns/1ps
`define CHK(nm, e, a) begin n_compared++; if ((a) !== (e)) begin \
  err_total++; $display("wrong value %s exp %h got %h", nm, e, a); end end
module timer16_count_modes_bench;
  logic clk = 0, rstn = 0, countWr = 0, cmpAWr = 0, cmpBWr = 0, captWr = 0;
  logic ovfClr = 0, cmpAClr = 0, cmpBClr = 0, captClr = 0;
  logic pinDirA = 0, pinDirB = 0;
  logic [3:0]  waveMode = 4'h0;
  logic [1:0]  actionA = 2'h0, actionB = 2'h0;
  logic [2:0]  clockSel = 3'h0;
  logic [15:0] countWrData = 16'h0, wrData = 16'h0;
  wire  [15:0] count, cmpA, cmpB, captTop;
  wire ovfFlag, cmpAFlag, cmpBFlag, captFlag, outA, outB, lvl;
  wire pinOutA, pinOeA, pinOutB, pinOeB;
  int err_total = 0, n_compared = 0, cyc = 0, n, top;
  int dv[5] = '{1, 8, 64, 256, 1024};
  timer16_count_modes i_timer16_count_modes (.clk, .rstn, .waveMode,
    .actionA, .actionB, .clockSel, .countWr, .countWrData, .cmpAWr, .cmpBWr,
    .captWr, .wrData, .ovfClr, .cmpAClr, .cmpBClr, .captClr, .pinDirA,
    .pinDirB, .count, .cmpA, .cmpB, .captTop, .ovfFlag, .cmpAFlag, .cmpBFlag,
    .captFlag, .outA, .outB, .pinOutA, .pinOeA, .pinOutB, .pinOeB);
  pin_load i_pin_load (.pinOutA, .pinOeA, .lvl);
  always #12.5 clk = ~clk;
  //////////////////////////////////////////////////////////////////////////
  task step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // one-cycle write strobe: 0 count, 1 compare a, 2 compare b, 3 capture
  task wr(input int k, input logic [15:0] v);
    @(posedge clk);
    countWr <= (k == 0); cmpAWr <= (k == 1);
    cmpBWr <= (k == 2); captWr <= (k == 3);
    countWrData <= v; wrData <= v;
    @(posedge clk);
    {countWr, cmpAWr, cmpBWr, captWr} <= 4'h0;
    #1;
  endtask
  task clr;
    @(posedge clk);
    {ovfClr, cmpAClr, cmpBClr, captClr} <= 4'hf;
    @(posedge clk);
    {ovfClr, cmpAClr, cmpBClr, captClr} <= 4'h0;
    #1;
  endtask
  // bounded wait, a stuck counter counts as a mismatch
  task wait_cnt(input logic [15:0] v);
    int i;
    i = 0;
    // step off the launching edge before the first look at the count
    #1;
    while (count !== v && i < 3000)
    begin
      step(1);
      i++;
    end
    if (i == 3000) err_total++;
  endtask
  task report_and_stop;
    $display("compared %0d, wrong %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // cut a hang short; the tests need well under this many cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      report_and_stop;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    step(1);
    `CHK("count", 16'h0000, count)
    `CHK("ovf", 1'b0, ovfFlag)
    `CHK("outA", 1'b0, outA)
    @(posedge clk) clockSel <= 3'h1;
    wr(0, 16'hfffd);
    step(3);
    `CHK("count", 16'h0000, count)
    `CHK("ovf", 1'b1, ovfFlag)
    step(2);
    `CHK("count", 16'h0002, count)
    `CHK("ovf", 1'b1, ovfFlag)
    $display("test normal done");
    clr;
    @(posedge clk) {waveMode, actionA, pinDirA} <= {4'h4, 2'h1, 1'b1};
    wr(1, 16'h0003);
    `CHK("cmpA", 16'h0003, cmpA)
    wr(0, 16'h0000);
    step(4);
    `CHK("count", 16'h0000, count)
    `CHK("cmpAFlag", 1'b1, cmpAFlag)
    `CHK("outA", 1'b1, outA)
    step(1);
    `CHK("pin", 1'b1, lvl)
    @(posedge clk) pinDirA <= 1'b0;
    step(2);
    `CHK("pin", 1'b0, lvl)
    $display("test ctc done");
    @(posedge clk) waveMode <= 4'hc;
    wr(3, 16'h0002);
    `CHK("captTop", 16'h0002, captTop)
    wr(0, 16'hfffe);
    clr;
    `CHK("count", 16'h0000, count)
    `CHK("ovf", 1'b1, ovfFlag)
    `CHK("captFlag", 1'b0, captFlag)
    step(3);
    `CHK("count", 16'h0000, count)
    `CHK("captFlag", 1'b1, captFlag)
    $display("test capture top done");
    @(posedge clk) {clockSel, waveMode} <= {3'h0, 4'hf};
    wr(1, 16'h0006);
    wr(2, 16'h0001);
    wr(0, 16'h0000);
    `CHK("cmpA", 16'h0003, cmpA)
    top = 3;
    // pass 0 non-inverted with pin b released, pass 1 inverted and driven
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clk) {actionB, pinDirB} <= {2'h2 + k[1:0], k[0]};
      clr;
      @(posedge clk) clockSel <= 3'h1;
      wait_cnt(top[15:0]);
      step(1);
      `CHK("count", 16'h0000, count)
      `CHK("ovf", 1'b1, ovfFlag)
      `CHK("cmpAFlag", 1'b1, cmpAFlag)
      `CHK("cmpA", 16'h0006, cmpA)
      `CHK("cmpB", 16'h0001, cmpB)
      `CHK("outB", k == 0, outB)
      wait_cnt(16'h0001);
      step(1);
      `CHK("outB", k == 1, outB)
      `CHK("cmpBFlag", 1'b1, cmpBFlag)
      step(1);
      `CHK("pinOutB", k == 1, pinOutB)
      `CHK("pinOeB", k == 1, pinOeB)
      top = 6;
    end
    $display("test fast pwm done");
    @(posedge clk) {clockSel, waveMode} <= {3'h0, 4'h5};
    wr(1, 16'h1234);
    wr(0, 16'h00fe);
    @(posedge clk) clockSel <= 3'h1;
    wait_cnt(16'h00ff);
    step(1);
    `CHK("count", 16'h0000, count)
    `CHK("cmpA", 16'h0034, cmpA)
    $display("test fixed top done");
    @(posedge clk) waveMode <= 4'h4;
    wr(1, 16'h0005);
    wr(0, 16'h0005);
    step(1);
    `CHK("count", 16'h0006, count)
    $display("test write block done");
    // capture top in fast pwm acts at once; ten-bit top masks compare a
    @(posedge clk) waveMode <= 4'he;
    wr(3, 16'h0004);
    `CHK("captTop", 16'h0004, captTop)
    wr(0, 16'h0000);
    wait_cnt(16'h0004);
    step(1);
    `CHK("count", 16'h0000, count)
    `CHK("captFlag", 1'b1, captFlag)
    @(posedge clk) waveMode <= 4'h7;
    wr(1, 16'hfedc);
    wr(0, 16'h03fe);
    wait_cnt(16'h0000);
    `CHK("cmpA", 16'h02dc, cmpA)
    $display("test register top done");
    @(posedge clk) waveMode <= 4'h0;
    for (int s = 1; s < 6; s++)
    begin
      @(posedge clk) clockSel <= s[2:0];
      wr(0, 16'h0000);
      wait_cnt(16'h0001);
      n = 0;
      while (count === 16'h0001 && n < 2000)
      begin
        step(1);
        n++;
      end
      `CHK("ticks", dv[s - 1], n)
    end
    $display("test prescaler done");
    report_and_stop;
  end
endmodule // timer16_count_modes_bench
bind timer16_count_modes timer16_count_modes_chk i_chk (.clk, .rstn,
  .waveMode, .actionA, .actionB, .clockSel, .countWr, .countWrData, .ovfClr,
  .pinDirA, .count, .cmpA, .cmpB, .captTop, .ovfFlag, .cmpAFlag, .captFlag,
  .outA, .outB, .pinOutA, .pinOeA);
